/* File: hdl/memory_map_decoder_map.vh */
// constants for the per-master address decoder and internal memory map
// assumes inclusion by hdl/memory_map_decoder.v only
`ifndef MEMORY_MAP_DECODER_MAP_VH
`define MEMORY_MAP_DECODER_MAP_VH

// slave target codes
`define TGT_NONE       3'h0
`define TGT_SRAM       3'h1
`define TGT_ROM        3'h2
`define TGT_HOSTPORT   3'h3
`define TGT_EXTBUS     3'h4
`define TGT_PERIPH     3'h5
// sram sub-region codes
`define SUB_A          2'h0
`define SUB_B          2'h1
`define SUB_C          2'h2
// area numbers (top four address bits)
`define AREA_INTERNAL  4'h0
`define AREA_EXT_FIRST 4'h1
`define AREA_EXT_LAST  4'h8
`define AREA_PERIPH    4'hF
// internal 1 MB regions (address bits 27:20)
`define REG_BOOT       8'h00
`define REG_SRAM_A     8'h01
`define REG_SRAM_B     8'h02
`define REG_SRAM_C     8'h03
`define REG_ROM        8'h04
`define REG_USBH       8'h05
`define REG_DISP       8'h06
// rom size: 32 KB, offset width 15
`define ROM_OFS_BITS   15
// sram block: 16 KB, offset width 14
`define BLK_OFS_BITS   14
`define BLK_COUNT      4'hA
// tcm size codes: 0=0 KB,1=16 KB,2=32 KB,3=64 KB
`define TCM_SIZE_RESET 2'h0
// master numbers
`define M_INSTR        3'h0
`define M_DATA         3'h1
`define M_PDMA         3'h2
`define M_DISP         3'h3
`define M_USBH         3'h4
`define NUM_MASTERS    5

`endif

/* File: hdl/memory_map_decoder.v */
// per-master address decoder, boot/remap selection and internal sram block partition
// assumes addresses from five masters are synchronous to mclk and that the
// round-robin choice between masters is made by the arbiter beside each slave
`timescale 1ns/1ps
`include "memory_map_decoder_map.vh"

module memory_map_decoder #(
    parameter NM = `NUM_MASTERS                    // number of masters
) (
    input  wire               mclk,                // bus clock
    input  wire               nrst,                // system reset, active low
    input  wire               boot_select_pin,     // boot strap, high selects internal rom
    input  wire               zero_map_bit_instr_master, // remap for instruction master
    input  wire               zero_map_bit_data_master,  // remap for data master
    input  wire [1:0]         sram_a_size,         // instr_tight_ram size code
    input  wire [1:0]         sram_b_size,         // data_tight_ram size code
    input  wire [NM*32-1:0]   addr,                // request address per master
    input  wire [NM-1:0]      req,                 // request valid per master
    input  wire [NM-1:0]      grant_sram,          // sram arbiter grant per master
    input  wire [NM-1:0]      grant_rom,           // rom arbiter grant per master
    input  wire [NM-1:0]      grant_hostport,      // display/usb port arbiter grant
    input  wire [NM-1:0]      grant_extbus,        // external_bus_port arbiter grant
    input  wire [NM-1:0]      grant_periph,        // peripheral bridge arbiter grant
    output reg  [NM*3-1:0]    target,              // decoded slave per master
    output reg  [NM-1:0]      err_resp,            // error response per master
    output reg  [NM*8-1:0]    ext_select_n,        // external selects zero..seven, active low
    output reg  [NM*18-1:0]   sram_phys,           // physical sram address per master
    output reg  [NM*15-1:0]   rom_ofs,             // rom offset per master
    output reg  [NM*28-1:0]   local_addr,          // address within slave per master
    output reg                boot_internal,       // latched boot choice
    output reg                remap_instr,         // instruction master remap state
    output reg                remap_data           // data master remap state
);

    // reset release through two flops
    reg rst_s1;
    reg rst_n;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // tcm size in blocks from size code
    function [3:0] blocks_of;
        input [1:0] code;
        begin
            case (code)
                2'h0:    blocks_of = 4'h0;
                2'h1:    blocks_of = 4'h1;
                2'h2:    blocks_of = 4'h2;
                default: blocks_of = 4'h4;
            endcase
        end
    endfunction

    // physical block for a given sram sub-region and block index
    function [4:0] phys_block; // bit4 set means beyond region (unmapped)
        input [1:0] sub;
        input [4:0] idx;
        input [3:0] na;
        input [3:0] nb;
        reg   [3:0] k;
        reg   [3:0] j;
        reg   [3:0] cnt;
        reg   [4:0] res;
        begin
            res = 5'h10;
            cnt = 4'h0;
            k   = 4'h0;
            j   = 4'h0;
            case (sub)
                `SUB_A: if (idx < {1'b0, na}) res = 5'h03 - idx;
                `SUB_B: if (idx < {1'b0, nb}) res = 5'h07 - idx;
                `SUB_C: begin
                    if (idx == 5'h00) res = 5'h09;
                    else if (idx == 5'h01) res = 5'h08;
                    else begin
                        // free blocks 7..0 descending, skipping tcm-owned ones
                        for (k = 4'h0; k < 4'h8; k = k + 4'h1) begin
                            j = 4'h7 - k;
                            if (!((j <= 4'h3 && (4'h3 - j) < na) ||
                                  (j >= 4'h4 && (4'h7 - j) < nb))) begin
                                if ({1'b0, cnt} == idx - 5'h02) res = {1'b0, j};
                                cnt = cnt + 4'h1;
                            end
                        end
                    end
                end
                default: res = 5'h10;
            endcase
            phys_block = res;
        end
    endfunction

    // boot pin caught at reset release, remap bits cleared by reset
    reg        in_reset;
    reg  [1:0] sz_a;
    reg  [1:0] sz_b;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_reset      <= 1'b1;
            boot_internal <= 1'b0;
            remap_instr   <= 1'b0;
            remap_data    <= 1'b0;
            sz_a          <= `TCM_SIZE_RESET;
            sz_b          <= `TCM_SIZE_RESET;
        end else begin
            in_reset <= 1'b0;
            if (in_reset) boot_internal <= boot_select_pin;
            remap_instr <= zero_map_bit_instr_master;
            remap_data  <= zero_map_bit_data_master;
            sz_a        <= sram_a_size;
            sz_b        <= sram_b_size;
        end
    end

    wire [3:0] na = blocks_of(sz_a);
    wire [3:0] nb = blocks_of(sz_b);

    // independent decoder per master, one pass of the loop per master
    reg  [NM*3-1:0]  next_target;
    reg  [NM-1:0]    next_err;
    reg  [NM*8-1:0]  next_sel_n;
    reg  [NM*18-1:0] next_phys;
    reg  [NM*15-1:0] next_rom;
    reg  [NM*28-1:0] next_local;
    integer m;
    reg  [31:0] a;
    reg  [2:0]  t;
    reg  [1:0]  sub;
    reg  [4:0]  pb;
    reg         remap_m;
    reg  [4:0]  grants;
    always @* begin
        // defaults: nothing decoded, every external select released
        next_target = {NM*3{1'b0}};
        next_err    = {NM{1'b0}};
        next_sel_n  = {NM*8{1'b1}};
        next_phys   = {NM*18{1'b0}};
        next_rom    = {NM*15{1'b0}};
        next_local  = {NM*28{1'b0}};
        a       = 32'h0;
        t       = `TGT_NONE;
        sub     = `SUB_C;
        pb      = 5'h10;
        remap_m = 1'b0;
        grants  = 5'h0;
        for (m = 0; m < NM; m = m + 1) begin
            // working copies, nothing carried from one master to the next
            a       = addr[m*32 +: 32];
            t       = `TGT_NONE;
            sub     = `SUB_C;
            pb      = 5'h10;
            // only the two processor masters own a remap bit
            remap_m = (m == 0) ? remap_instr : ((m == 1) ? remap_data : 1'b0);
            // area zero: second level decode in 1 MB regions
            if (a[31:28] == `AREA_INTERNAL) begin
                case (a[27:20])
                    `REG_BOOT: begin
                        // the other masters see a hole at zero
                        if (m <= 1) begin
                            if (remap_m) begin
                                t   = `TGT_SRAM;
                                sub = `SUB_C;
                            end else if (boot_internal) begin
                                t = `TGT_ROM;
                            end else begin
                                t = `TGT_EXTBUS;
                            end
                        end
                    end
                    `REG_SRAM_A: begin
                        t   = `TGT_SRAM;
                        sub = `SUB_A;
                    end
                    `REG_SRAM_B: begin
                        t   = `TGT_SRAM;
                        sub = `SUB_B;
                    end
                    `REG_SRAM_C: begin
                        t   = `TGT_SRAM;
                        sub = `SUB_C;
                    end
                    `REG_ROM: begin
                        t = `TGT_ROM;
                    end
                    `REG_USBH, `REG_DISP: begin
                        t = `TGT_HOSTPORT;
                    end
                    default: begin
                        t = `TGT_NONE;
                    end
                endcase
                // sram offset must fall inside the current partition
                if (t == `TGT_SRAM) begin
                    pb = phys_block(sub, {1'b0, a[17:14]}, na, nb);
                    if (a[19:18] != 2'h0 || pb[4]) begin
                        t = `TGT_NONE;
                    end else begin
                        next_phys[m*18 +: 18] = {pb[3:0], a[13:0]};
                    end
                end
                // rom image is 32 KB, the rest of its region is a hole
                if (t == `TGT_ROM) begin
                    if (a[19:15] != 5'h00) begin
                        t = `TGT_NONE;
                    end else begin
                        next_rom[m*15 +: 15] = a[14:0];
                    end
                end
                // external boot goes through select zero
                if (t == `TGT_EXTBUS) begin
                    next_sel_n[m*8] = 1'b0;
                end
            end else if (a[31:28] >= `AREA_EXT_FIRST && a[31:28] <= `AREA_EXT_LAST) begin
                // area n drives select n-1
                t = `TGT_EXTBUS;
                next_sel_n[m*8 + a[31:28] - 1] = 1'b0;
            end else if (a[31:28] == `AREA_PERIPH) begin
                t = `TGT_PERIPH;
            end
            // each slave's arbiter gates its own master independently
            grants = {grant_periph[m], grant_extbus[m], grant_hostport[m], grant_rom[m], grant_sram[m]};
            if (t != `TGT_NONE && !grants[t - 3'h1]) begin
                next_sel_n[m*8 +: 8] = 8'hFF;
            end
            // an idle master drives no select
            if (!req[m]) begin
                next_sel_n[m*8 +: 8] = 8'hFF;
            end
            // unmapped access answers with an error so the master aborts
            next_err[m]            = req[m] && (t == `TGT_NONE);
            next_target[m*3 +: 3]  = t;
            next_local[m*28 +: 28] = a[27:0];
        end
    end

    // decoded slave per master
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            target <= {NM*3{1'b0}};
        end else begin
            target <= next_target;
        end
    end

    // error response per master
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            err_resp <= {NM{1'b0}};
        end else begin
            err_resp <= next_err;
        end
    end

    // external selects, released during reset
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_select_n <= {NM*8{1'b1}};
        end else begin
            ext_select_n <= next_sel_n;
        end
    end

    // physical sram block and offset
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sram_phys <= {NM*18{1'b0}};
        end else begin
            sram_phys <= next_phys;
        end
    end

    // rom byte offset
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rom_ofs <= {NM*15{1'b0}};
        end else begin
            rom_ofs <= next_rom;
        end
    end

    // address within the selected slave
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            local_addr <= {NM*28{1'b0}};
        end else begin
            local_addr <= next_local;
        end
    end

endmodule // memory_map_decoder

/* File: bench/memory_map_decoder_props.sv */
// checker for the decoder's port behaviour on masters 0 and 2
// assumes mclk is the bus clock and nrst the active-low system reset
`timescale 1ns/1ps
module memory_map_decoder_props #(parameter NM = 5) (
    input wire [NM*32-1:0] addr,          // request addresses
    input wire             mclk,          // bus clock
    input wire             nrst,          // reset, active low
    input wire [NM-1:0]    req,           // request valid
    input wire [NM-1:0]    grant_extbus,  // external port grant
    input wire [NM*3-1:0]  target,        // decoded slave
    input wire [NM-1:0]    err_resp,      // error response
    input wire [NM*8-1:0]  ext_select_n,  // external selects
    input wire [NM*18-1:0] sram_phys,     // physical sram address
    input wire [NM*15-1:0] rom_ofs,       // rom offset
    input wire             boot_internal, // latched boot choice
    input wire             remap_instr,   // instr remap state
    input wire             remap_data     // data remap state
);
    reg  [2:0] up;
    wire       live = (up == 3'h7);
    // skips the edges of the reset synchroniser
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_ext_sel;
        live && req[2] && grant_extbus[2] && addr[95:92] >= 4'h1 && addr[95:92] <= 4'h8
            |=> ext_select_n[23:16] == ~(8'h01 << ($past(addr[95:92]) - 4'h1));
    endproperty
    a_ext_sel: assert property (p_ext_sel) else $error("wrong external select");
    property p_no_grant;
        live && !grant_extbus[2] |=> ext_select_n[23:16] == 8'hFF;
    endproperty
    a_no_grant: assert property (p_no_grant) else $error("select without grant");
    property p_ext_tgt;
        live && addr[95:92] >= 4'h1 && addr[95:92] <= 4'h8 |=> target[8:6] == 3'h4;
    endproperty
    a_ext_tgt: assert property (p_ext_tgt) else $error("area not external");
    property p_periph;
        live && addr[95:92] == 4'hF |=> target[8:6] == 3'h5;
    endproperty
    a_periph: assert property (p_periph) else $error("area not peripheral");
    property p_unmap;
        live && req[2] && addr[95:92] >= 4'h9 && addr[95:92] <= 4'hE |=> err_resp[2] && target[8:6] == 3'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unused area not refused");
    property p_dma_zero;
        live && addr[95:84] == 12'h000 |=> target[8:6] == 3'h0;
    endproperty
    a_dma_zero: assert property (p_dma_zero) else $error("zero region mapped for dma");
    property p_rom;
        live && addr[31:15] == 17'h00080 |=> target[2:0] == 3'h2 && rom_ofs[14:0] == $past(addr[14:0]);
    endproperty
    a_rom: assert property (p_rom) else $error("rom base wrong");
    property p_sramc;
        live && addr[95:79] == 17'h00060 |=> target[8:6] == 3'h1 && sram_phys[53:50] == ($past(addr[78]) ? 4'h8 : 4'h9);
    endproperty
    a_sramc: assert property (p_sramc) else $error("sram c fixed block wrong");
    property p_boot_rom;
        live && addr[31:15] == 17'h0 && !remap_instr && boot_internal ##1 !remap_instr |-> target[2:0] == 3'h2;
    endproperty
    a_boot_rom: assert property (p_boot_rom) else $error("zero not rom");
    property p_remap_rst;
        $rose(nrst) |-> !remap_instr && !remap_data;
    endproperty
    a_remap_rst: assert property (p_remap_rst) else $error("remap not cleared");
    property p_boot_hold;
        live |-> $stable(boot_internal);
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("boot choice moved");
endmodule // memory_map_decoder_props
bind memory_map_decoder memory_map_decoder_props #(.NM(NM)) memory_map_decoder_props_i (.addr, .mclk, .nrst, .req,
    .grant_extbus, .target, .err_resp, .ext_select_n, .sram_phys, .rom_ofs, .boot_internal, .remap_instr, .remap_data);

/* File: bench/slave_arbiter_model.sv */
// far-side model: one arbiter per slave granting the masters
// assumes requests from the bench; stall keeps the external arbiter busy
`timescale 1ns/1ps
module slave_arbiter_model (
    input  wire [4:0] req,   // request per master
    input  wire       stall, // slow external arbiter
    output wire [4:0] g_s,   // sram grants
    output wire [4:0] g_r,   // rom grants
    output wire [4:0] g_h,   // host port grants
    output wire [4:0] g_e,   // external port grants
    output wire [4:0] g_p    // peripheral grants
);
    // each slave decides on its own
    assign g_s = req;
    assign g_r = req;
    assign g_h = req;
    assign g_e = stall ? 5'h00 : req;
    assign g_p = req;
endmodule // slave_arbiter_model

/* File: bench/test_memory_map_decoder.sv */
// self-checking bench for the per-master decoder
// assumes the decoder's 25 MHz clock and one-cycle answer latency
`timescale 1ns/1ps
module test_memory_map_decoder;
    reg          mclk, nrst, pin, rb0, rb1, stall;
    reg  [1:0]   sa, sb;
    reg  [159:0] addr;
    reg  [4:0]   req;
    wire [4:0]   gs, gr, gh, ge, gp, err_resp;
    wire [14:0]  target;
    wire [39:0]  ext_select_n;
    wire [89:0]  sram_phys;
    wire [74:0]  rom_ofs;
    wire [139:0] local_addr;
    wire         boot_internal, remap_instr, remap_data;
    integer      n_mismatch, n_compared, k;
    localparam [27:0] CLIST = 28'h9865410;
    memory_map_decoder memory_map_decoder_i (.mclk(mclk), .nrst(nrst), .boot_select_pin(pin),
        .zero_map_bit_instr_master(rb0), .zero_map_bit_data_master(rb1), .sram_a_size(sa), .sram_b_size(sb),
        .addr(addr), .req(req), .grant_sram(gs), .grant_rom(gr), .grant_hostport(gh), .grant_extbus(ge),
        .grant_periph(gp), .target(target), .err_resp(err_resp), .ext_select_n(ext_select_n), .sram_phys(sram_phys),
        .rom_ofs(rom_ofs), .local_addr(local_addr), .boot_internal(boot_internal), .remap_instr(remap_instr),
        .remap_data(remap_data));
    slave_arbiter_model slave_arbiter_model_i (.req(req), .stall(stall), .g_s(gs), .g_r(gr), .g_h(gh), .g_e(ge),
        .g_p(gp));
    // bus clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task summarize;
        begin
            if (n_mismatch == 0 && n_compared > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task do_reset(input p);
        begin
            @(posedge mclk);
            nrst <= 1'b0;
            pin <= p;
            repeat (10) @(posedge mclk);
            nrst <= 1'b1;
            repeat (4) @(posedge mclk);
        end
    endtask
    // one request of master m, answer read after the next edge
    task tg(input [2:0] m, input [31:0] a, input [2:0] t);
        begin
            @(posedge mclk);
            addr[m*32+:32] <= a;
            req <= 5'h01 << m;
            @(posedge mclk);
            @(negedge mclk);
            chk(target[m*3+:3], t);
            chk(err_resp[m], t == 3'h0);
            chk(local_addr[m*28+:28], a[27:0]);
            @(posedge mclk);
        end
    endtask
    task sr(input [31:0] a, input [3:0] blk);
        begin
            tg(3'h2, a, (blk == 4'hF) ? 3'h0 : 3'h1);
            if (blk != 4'hF) chk(sram_phys[53:50], blk);
        end
    endtask
    task t_sram;
        begin
            sr(32'h00324000, 4'h0);
            sr(32'h00100000, 4'hF);
            sa <= 2'h3;
            sb <= 2'h3;
            repeat (3) @(posedge mclk);
            for (k = 0; k < 4; k = k + 1) begin
                sr(32'h00100000 + k * 32'h4000, 4'h3 - k[3:0]);
                sr(32'h00200000 + k * 32'h4000, 4'h7 - k[3:0]);
            end
            sr(32'h00304000, 4'h8);
            sr(32'h00308000, 4'hF);
            sa <= 2'h2;
            sb <= 2'h1;
            repeat (3) @(posedge mclk);
            for (k = 0; k < 7; k = k + 1)
                sr(32'h00300000 + k * 32'h4000, CLIST[(6 - k) * 4 +: 4]);
            sr(32'h0031C000, 4'hF);
            sr(32'h00108000, 4'hF);
            sr(32'h00204000, 4'hF);
        end
    endtask
    task t_areas;
        begin
            for (k = 0; k < 16; k = k + 1) begin
                tg(3'h2, {k[3:0], 28'h0000010}, (k >= 1 && k <= 8) ? 3'h4 : (k == 15) ? 3'h5 : 3'h0);
                chk(ext_select_n[23:16], (k >= 1 && k <= 8) ? {24'h0, ~(8'h01 << (k - 1))} : 32'hFF);
            end
            tg(3'h3, 32'h00500000, 3'h3);
            tg(3'h4, 32'h00600000, 3'h3);
            stall <= 1'b1;
            tg(3'h2, 32'h10000000, 3'h4);
            chk(ext_select_n[23:16], 32'hFF);
            stall <= 1'b0;
        end
    endtask
    task t_boot;
        begin
            tg(3'h0, 32'h00000000, 3'h2);
            chk({remap_instr, remap_data}, 32'h0);
            rb0 <= 1'b1;
            repeat (2) @(posedge mclk);
            tg(3'h0, 32'h00000008, 3'h1);
            chk(sram_phys[17:14], 4'h9);
            tg(3'h1, 32'h00000008, 3'h2);
            rb1 <= 1'b1;
            repeat (2) @(posedge mclk);
            tg(3'h1, 32'h00000000, 3'h1);
            tg(3'h0, 32'h00407FFC, 3'h2);
            chk(rom_ofs[14:0], 32'h7FFC);
            tg(3'h0, 32'h00408000, 3'h0);
            rb0 <= 1'b0;
            rb1 <= 1'b0;
            do_reset(1'b0);
            pin <= 1'b1;
            tg(3'h1, 32'h00000000, 3'h4);
            chk(ext_select_n[15:8], 32'hFE);
            chk(boot_internal, 32'h0);
        end
    endtask
    // main sequence
    initial begin
        {nrst, pin, rb0, rb1, stall, sa, sb, req} = 0;
        addr = 160'h0;
        n_mismatch = 0;
        n_compared = 0;
        do_reset(1'b1);
        t_sram;
        t_areas;
        t_boot;
        summarize;
    end
    // cuts a hang short
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        summarize;
    end
endmodule // test_memory_map_decoder
